// File: core/power_mode_control.sv
// power-mode sequencer: normal, light sleep and deep sleep
`timescale 1ns/1ps
`default_nettype none
`include "power_mode_defs.svh"
module power_mode_control #(
  // wake waits in clock cycles, rounded up so that a wait never ends early
  parameter int LIGHT_WAKE_CYC = (`LIGHT_WAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int DEEP_PWRUP_CYC = (`DEEP_PWRUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_reset_n,
  // decoded register write from the serial interface (same clock)
  input  wire power_mode_pkg::reg_write_s i_reg_write,
  // start/select pin, asynchronous
  input  wire logic                       i_convert_start_select_pin,
  // conversion engine reports end of conversion (same clock)
  input  wire logic                       i_conversion_done,
  // power and status
  output logic                            o_analog_power_on,
  output logic                            o_acquisition_reduced_power,
  output logic                            o_ready_output,
  output logic                            o_start_conversion,
  output logic                            o_light_sleep_enable_bit,
  output logic                            o_deep_sleep_request_bit
);

  // true when a valid write strobe targets the given address
  function automatic logic write_hits(input power_mode_pkg::reg_write_s rw,
                                      input logic [7:0]                 addr);
    return rw.valid && (rw.addr == addr);
  endfunction

  // synchroniser and edge history for the pin
  logic                         pin_meta;             // first stage, may be metastable
  logic                         pin_sync;             // second stage, safe to read
  logic                         pin_prev;             // one cycle older, for edges
  logic                         rise;                 // pin went high
  logic                         fall;                 // pin went low

  // register state
  logic                         unlocked;             // key seen, single use
  logic                         next_unlocked;        // next key state
  logic [1:0]                   pwrctl;               // light-sleep and deep-sleep bits
  logic [1:0]                   next_pwrctl;          // next control bits
  logic                         hit_key;              // write to the unlock address
  logic                         hit_ctl;              // write to the control address

  // sequencer state
  power_mode_pkg::power_state_e state;                // current mode
  power_mode_pkg::power_state_e next_state;           // mode after this edge
  logic [`WAKE_CNT_W-1:0]       wait_cnt;             // wake countdown
  logic [`WAKE_CNT_W-1:0]       next_wait_cnt;        // next countdown value
  logic                         next_analog;          // next analog power level
  logic                         next_acquisition_low; // next reduced-power level
  logic                         next_ready;           // next ready level
  logic                         next_start;           // next start pulse

  // edges come only from the synchronised copies, never from the raw pin
  assign rise = pin_sync & ~pin_prev;
  assign fall = ~pin_sync & pin_prev;

  // address decode shared by the key and the control paths
  assign hit_key = write_hits(i_reg_write, `UNLOCK_ADDR);
  assign hit_ctl = write_hits(i_reg_write, `PWRCTL_ADDR);

  // two-flop synchroniser, then edge history
  // resets to the idle low level so no false edge follows reset
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      pin_meta <= i_convert_start_select_pin;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // unlock key and power-control register
  // a key of any other value relocks, so a stray write cannot leave the gate open
  always_comb begin
    next_unlocked = unlocked;
    next_pwrctl   = pwrctl;
    if (hit_key) begin
      // only the exact key opens the gate
      next_unlocked = (i_reg_write.data == `UNLOCK_VALUE);
    end else if (hit_ctl) begin
      // locked writes are dropped; one unlock allows one update
      if (unlocked) begin
        next_pwrctl = i_reg_write.data[1:0];
      end
      // the gate closes after every control write, taken or not
      next_unlocked = 1'b0;
    end
  end

  // key and control bits; only registering here
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      unlocked <= 1'b0;
      pwrctl   <= `PWRCTL_RESET;
    end else begin
      unlocked <= next_unlocked;
      pwrctl   <= next_pwrctl;
    end
  end

  // mode sequencer
  // the countdown runs down by itself and is only loaded on entry to a wake state
  always_comb begin
    next_state    = state;
    next_wait_cnt = (wait_cnt != 32'h0) ? wait_cnt - 32'h1 : 32'h0;
    next_start    = 1'b0;
    case (state)
      power_mode_pkg::st_normal: begin
        // deep sleep wins over a conversion when both are asked for
        if (rise && pwrctl[`DEEP_SLEEP_POS]) begin
          next_state = power_mode_pkg::st_deep_sleep;
        end else if (rise) begin
          // analog stays powered, so a conversion starts at once
          next_state = power_mode_pkg::st_convert;
          next_start = 1'b1;
        end
      end
      power_mode_pkg::st_convert: begin
        if (i_conversion_done) begin
          // light sleep only if the pin still stands high
          if (pwrctl[`LIGHT_SLEEP_POS] && pin_sync) begin
            next_state = power_mode_pkg::st_light_sleep;
          end else begin
            next_state = power_mode_pkg::st_normal;
          end
        end
      end
      power_mode_pkg::st_light_sleep: begin
        // stays asleep while the pin is high
        if (fall) begin
          next_state    = power_mode_pkg::st_light_wake;
          next_wait_cnt = 32'(LIGHT_WAKE_CYC);
        end
      end
      power_mode_pkg::st_light_wake: begin
        // a rise before the wake time is the host's fault; ignored
        if (wait_cnt == 32'h0) begin
          next_state = power_mode_pkg::st_normal;
        end
      end
      power_mode_pkg::st_deep_sleep: begin
        // register writes still land here, so the host can clear the bit
        if (!pwrctl[`DEEP_SLEEP_POS]) begin
          next_state    = power_mode_pkg::st_deep_wake;
          next_wait_cnt = 32'(DEEP_PWRUP_CYC);
        end
      end
      power_mode_pkg::st_deep_wake: begin
        // pin edges are ignored until the power-up wait is over
        if (wait_cnt == 32'h0) begin
          next_state = power_mode_pkg::st_normal;
        end
      end
      default: begin
        // an illegal code falls back to normal, analog on
        next_state = power_mode_pkg::st_normal;
      end
    endcase
    // output levels follow the next state, so they change with the state
    next_analog          = (next_state != power_mode_pkg::st_deep_sleep);
    next_acquisition_low = (next_state == power_mode_pkg::st_light_sleep);
    next_ready           = (next_state == power_mode_pkg::st_normal)
                           || (next_state == power_mode_pkg::st_deep_sleep)
                           || (next_state == power_mode_pkg::st_deep_wake);
  end

  // sequencer state and registered outputs
  // every output comes straight from a flop, so no glitch reaches a pin
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state                       <= power_mode_pkg::st_normal;
      wait_cnt                    <= 32'h0;
      o_analog_power_on           <= 1'b1;
      o_acquisition_reduced_power <= 1'b0;
      o_ready_output              <= 1'b1;
      o_start_conversion          <= 1'b0;
      o_light_sleep_enable_bit    <= 1'b0;
      o_deep_sleep_request_bit    <= 1'b0;
    end else begin
      state                       <= next_state;
      wait_cnt                    <= next_wait_cnt;
      o_analog_power_on           <= next_analog;
      o_acquisition_reduced_power <= next_acquisition_low;
      o_ready_output              <= next_ready;
      o_start_conversion          <= next_start;
      // bit outputs mirror the register in the same edge it is written
      o_light_sleep_enable_bit    <= next_pwrctl[`LIGHT_SLEEP_POS];
      o_deep_sleep_request_bit    <= next_pwrctl[`DEEP_SLEEP_POS];
    end
  end

  // limitation: deep sleep is entered only from normal mode; a request
  // made during a conversion or a light-sleep phase waits for the next
  // rise of the pin after the sequencer is back in normal mode.
  // trade-off: one shared countdown serves both wake waits, since the two
  // wake states can never be active at the same time.
  // the countdown is wide enough for the longest power-up wait at this clock.
endmodule
`default_nettype wire

// File: include/power_mode_defs.svh
// constants for the converter power-mode sequencer
// Summary of operation
// - normal mode keeps analog powered between conversions
// - light sleep at conversion end, pin high
// - light sleep lowers power during acquisition
// - pin falling edge starts light sleep wake
// - deep sleep entered on next pin rise in normal mode
// - deep sleep: analog off, interface and registers kept
// - ready output high while in deep sleep
// - clearing deep-sleep bit drives ready high
`ifndef POWER_MODE_DEFS_SVH
`define POWER_MODE_DEFS_SVH
`define UNLOCK_ADDR       8'h05
`define UNLOCK_VALUE      8'h69
`define PWRCTL_ADDR       8'h04
`define LIGHT_SLEEP_POS   1
`define DEEP_SLEEP_POS    0
`define PWRCTL_RESET      2'h0
`define WAKE_CNT_W        32
`define LIGHT_WAKE_NS     1000
`define DEEP_PWRUP_NS     10000000
`define CLK_PERIOD_NS     25
`endif

// File: include/power_mode_pkg.sv
// types for the converter power-mode sequencer
package power_mode_pkg;
  typedef enum logic [2:0] {
    st_normal, st_convert, st_light_sleep, st_light_wake, st_deep_sleep, st_deep_wake
  } power_state_e;
  // register write strobe with address and data
  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_s;
endpackage

// File: tb/power_mode_sva.sv
// checker: power-mode sequencer port relations
`timescale 1ns/1ps
`default_nettype none
module power_mode_sva (
  // clock, reset, host side
  input wire logic                       i_sys_clk,
  input wire logic                       i_reset_n,
  input wire power_mode_pkg::reg_write_s i_reg_write,
  input wire logic                       i_convert_start_select_pin,
  // power and status
  input wire logic                       o_analog_power_on,
  input wire logic                       o_acquisition_reduced_power,
  input wire logic                       o_ready_output,
  input wire logic                       o_light_sleep_enable_bit,
  input wire logic                       o_deep_sleep_request_bit
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  logic       open_ok;      // unlock seen, single use
  logic       next_open_ok; // next unlock state
  wire        wr4 = i_reg_write.valid && i_reg_write.addr == 8'h04;
  wire  [1:0] bits = {o_light_sleep_enable_bit, o_deep_sleep_request_bit};
  // any other data to the unlock address relocks
  always_comb begin
    next_open_ok = wr4 ? 1'b0 : open_ok;
    if (i_reg_write.valid && i_reg_write.addr == 8'h05) begin
      next_open_ok = i_reg_write.data == 8'h69;
    end
  end
  // unlock register
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) open_ok <= 1'b0;
    else open_ok <= next_open_ok;
  end
  property p_lock; wr4 && !open_ok |=> $stable(bits); endproperty
  a_lock: assert property (p_lock) else $error("locked write took effect");
  property p_take; wr4 && open_ok |=> bits == $past(i_reg_write.data[1:0]); endproperty
  a_take: assert property (p_take) else $error("unlocked write lost");
  property p_keep; !bits[0] && !$past(bits[0]) |-> o_analog_power_on; endproperty
  a_keep: assert property (p_keep) else $error("analog off in normal");
  property p_off; !o_analog_power_on |-> o_ready_output && (bits[0] || $past(bits[0])); endproperty
  a_off: assert property (p_off) else $error("bad deep sleep status");
  property p_wake; $fell(bits[0]) |-> o_ready_output [*2]; endproperty
  a_wake: assert property (p_wake) else $error("ready low on deep exit");
  property p_light;
    o_acquisition_reduced_power |-> !o_ready_output && o_analog_power_on;
  endproperty
  a_light: assert property (p_light) else $error("bad light sleep status");
  property p_exit;
    $fell(i_convert_start_select_pin) && o_acquisition_reduced_power
      |-> ##[1:6] !o_acquisition_reduced_power;
  endproperty
  a_exit: assert property (p_exit) else $error("light sleep not left");
  property p_deep_entry;
    $rose(i_convert_start_select_pin) && bits[0] && o_ready_output && o_analog_power_on
      |-> ##[2:6] !o_analog_power_on;
  endproperty
  a_deep_entry: assert property (p_deep_entry) else $error("deep sleep not entered");
endmodule
bind power_mode_control power_mode_sva i_sva (.i_sys_clk, .i_reset_n, .i_reg_write,
  .i_convert_start_select_pin, .o_analog_power_on, .o_acquisition_reduced_power,
  .o_ready_output, .o_light_sleep_enable_bit, .o_deep_sleep_request_bit);
`default_nettype wire

// File: tb/power_mode_host.sv
// host model: register writes and start/select pin
`timescale 1ns/1ps
`default_nettype none
module power_mode_host (
  // clock
  input  wire logic                      i_sys_clk,
  // toward the device
  output var power_mode_pkg::reg_write_s o_reg_write,
  output var logic                       o_pin
);
  initial begin
    o_reg_write = '0;
    o_pin = 1'b0;
  end
  // one strobe; idle bus shows inverted values so stale data never matches
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    o_reg_write <= '{1'b1, a, d};
    @(posedge i_sys_clk);
    o_reg_write <= '{1'b0, ~a, ~d};
  endtask
  // unlock first, then the control bits
  task automatic set_ctl(input logic [1:0] d);
    wr(8'h05, 8'h69);
    wr(8'h04, {6'h00, d});
  endtask
  // pin change after the wake wait the caller asks for
  task automatic pin(input logic v, input int wait_cyc);
    repeat (wait_cyc) @(posedge i_sys_clk);
    @(posedge i_sys_clk);
    o_pin <= v;
  endtask
endmodule
`default_nettype wire

// File: tb/power_mode_control_tb.sv
// testbench for the power-mode sequencer
`timescale 1ns/1ps
`default_nettype none
module power_mode_control_tb;
  localparam int LW = 4; // short light-sleep wake
  localparam int DW = 8; // short power-up count
  logic                       clk = 1'b0;
  logic                       rst_n = 1'b0;
  logic                       done = 1'b0;
  int                         fail_count = 0;
  int                         checked = 0;
  int                         starts;
  wire power_mode_pkg::reg_write_s wr;
  wire                        pin;
  logic                       an, red, rdy, st, lb, db;
  wire  [7:0]                 stat = {3'h0, an, red, rdy, lb, db}; // packed status
  always #12.5 clk = ~clk;
  power_mode_control #(.LIGHT_WAKE_CYC(LW), .DEEP_PWRUP_CYC(DW)) i_dut (.i_sys_clk(clk),
    .i_reset_n(rst_n), .i_reg_write(wr), .i_convert_start_select_pin(pin),
    .i_conversion_done(done), .o_analog_power_on(an), .o_acquisition_reduced_power(red),
    .o_ready_output(rdy), .o_start_conversion(st), .o_light_sleep_enable_bit(lb),
    .o_deep_sleep_request_bit(db));
  power_mode_host i_host (.i_sys_clk(clk), .o_reg_write(wr), .o_pin(pin));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // run n cycles; start pulses last one cycle, so count each one
  task automatic cyc(input int n);
    starts = 0;
    repeat (n) begin
      @(posedge clk);
      #1 starts += int'(st);
    end
  endtask
  task automatic finish_test;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic s_lock;
    i_host.wr(8'h04, 8'h03);
    cyc(2);
    chk(stat, 8'h14);
  endtask
  task automatic s_light;
    i_host.set_ctl(2'h2);
    i_host.pin(1'b1, 0);
    cyc(6);
    chk(8'(starts), 8'h01);
    @(posedge clk) done <= 1'b1;
    @(posedge clk) done <= 1'b0;
    cyc(3);
    chk(stat, 8'h1A);
    i_host.pin(1'b0, 0);
    cyc(5);
    chk(stat, 8'h12);
    cyc(LW + 2);
    chk(stat, 8'h16);
  endtask
  task automatic s_deep;
    i_host.set_ctl(2'h1);
    i_host.pin(1'b1, 0);
    cyc(6);
    chk(stat, 8'h05);
    i_host.pin(1'b0, 0);
    i_host.set_ctl(2'h0);
    cyc(1);
    chk(stat, 8'h14);
    i_host.pin(1'b1, DW + 2);
    cyc(6);
    chk(8'(starts), 8'h01);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    s_lock;
    s_light;
    s_deep;
    finish_test;
  end
endmodule
`default_nettype wire
